// ==== frame_length_collision_regs.v ====
/*
 * Register bank for collision position, emulated target state and
 * transmit frame length, with its interrupt status and the serializer
 * that sends frames of that length.
 * Assumes all inputs come from logic on the same clock; the register
 * port master reads data in the cycle after its read strobe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "frame_regs_consts.vh"

module frame_length_collision_regs #(
    parameter COUNT_WIDTH = 13
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // Receiver events
    input wire rx_frame_start,
    input wire rx_anticoll_cmd,
    input wire rx_collision,
    input wire [3:0] rx_coll_bytes,
    input wire [2:0] rx_coll_bits,
    input wire rx_coll_in_parity,
    input wire rx_hard_framing_error,
    // Card emulation
    input wire [3:0] target_state,
    input wire cmd_req_or_wakeup,
    // Transmit request and data
    input wire cmd_tx_start,
    input wire [7:0] tx_data,
    output wire tx_byte_take,
    output wire tx_bit,
    output wire tx_bit_valid,
    output wire tx_busy,
    // Interrupt
    output reg irq
);
    // Stored registers
    reg [7:0] coll_pos_reg; // Collision position display
    reg [7:0] coll_pos_next;
    reg [3:0] tgt_state_reg; // Target state display
    reg [7:0] tx_cnt_up_reg; // Byte count upper bits
    reg [7:0] tx_cnt_lo_reg; // Byte count low bits and trailing bits
    reg [7:0] irq_status_reg; // Sticky event bits
    reg [7:0] irq_status_next;
    reg [7:0] irq_mask_reg; // One enables a status bit
    reg [7:0] control_reg; // Anticollision and parity controls
    reg [7:0] rdata_next;

    // Events from the serializer and the checks below
    wire tx_done;
    reg [7:0] event_set;
    wire parity_setup_error;

    // Decoded write strobes
    wire wr_cnt_up = reg_write && (reg_addr == `OFS_TX_CNT_UP);
    wire wr_cnt_lo = reg_write && (reg_addr == `OFS_TX_CNT_LO);
    wire wr_status = reg_write && (reg_addr == `OFS_IRQ_STATUS);
    wire wr_mask = reg_write && (reg_addr == `OFS_IRQ_MASK);
    wire wr_control = reg_write && (reg_addr == `OFS_CONTROL);

    // Frame length fields
    wire [COUNT_WIDTH-1:0] tx_byte_count;
    wire [2:0] tx_extra_bits;

    // Upper eight from 22h, lower five from 23h
    assign tx_byte_count = {tx_cnt_up_reg, tx_cnt_lo_reg[7:3]};
    // Trailing bit count in bits 2-0
    assign tx_extra_bits = tx_cnt_lo_reg[2:0];

    // Anticollision set, idle card, trailing bits
    assign parity_setup_error = cmd_req_or_wakeup
        && control_reg[`CTL_ANTICOLL_BIT]
        && (tgt_state_reg == `TGT_IDLE)
        && (tx_extra_bits != 3'h0);

    // Next collision position value
    always @* begin
        coll_pos_next = coll_pos_reg;
        if (rx_anticoll_cmd) begin
            if (rx_collision) begin
                // Parity collision flag in bit 0
                coll_pos_next = {rx_coll_bytes, rx_coll_bits, rx_coll_in_parity};
            end else if (rx_frame_start) begin
                coll_pos_next = 8'h00;
            end
        end
    end

    // Event bits raised this cycle
    always @* begin
        event_set = 8'h00;
        event_set[`IRQ_COLL_BIT] = rx_anticoll_cmd && rx_collision;
        event_set[`IRQ_TXDONE_BIT] = tx_done;
        event_set[`IRQ_HARD_FRAMING_BIT] = rx_hard_framing_error;
        event_set[`IRQ_PARITY_BIT] = parity_setup_error;
    end

    // Sticky status; a set in the clearing cycle wins
    always @* begin
        irq_status_next = irq_status_reg;
        if (wr_status) begin
            irq_status_next = irq_status_reg & ~reg_wdata;
        end
        irq_status_next = irq_status_next | event_set;
    end

    // Read data mux; unmapped offsets answer zero
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr)
            `OFS_COLL_POS: rdata_next = coll_pos_reg;
            // State code, upper bits read zero
            `OFS_TGT_STATE: rdata_next = {4'h0, tgt_state_reg};
            `OFS_TX_CNT_UP: rdata_next = tx_cnt_up_reg;
            `OFS_TX_CNT_LO: rdata_next = tx_cnt_lo_reg;
            `OFS_IRQ_STATUS: rdata_next = irq_status_reg;
            `OFS_IRQ_MASK: rdata_next = irq_mask_reg;
            `OFS_CONTROL: rdata_next = control_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // Software written registers
    always @(posedge clock) begin
        if (rst) begin
            tx_cnt_up_reg <= `RST_TX_CNT;
            tx_cnt_lo_reg <= `RST_TX_CNT;
            irq_mask_reg <= `RST_IRQ_MASK;
            control_reg <= `RST_CONTROL;
        end else begin
            // Writes during a frame land now but only
            // take effect at the next start
            if (wr_cnt_up) begin
                tx_cnt_up_reg <= reg_wdata;
            end
            if (wr_cnt_lo) begin
                tx_cnt_lo_reg <= reg_wdata;
            end
            if (wr_mask) begin
                irq_mask_reg <= reg_wdata;
            end
            // Only the two defined control bits are stored
            if (wr_control) begin
                control_reg <= reg_wdata & 8'h03;
            end
        end
    end

    // Hardware driven displays and status
    always @(posedge clock) begin
        if (rst) begin
            coll_pos_reg <= `RST_COLL_POS;
            tgt_state_reg <= `TGT_POWER_OFF;
            irq_status_reg <= 8'h00;
        end else begin
            coll_pos_reg <= coll_pos_next;
            tgt_state_reg <= target_state;
            irq_status_reg <= irq_status_next;
        end
    end

    // Read data and interrupt outputs
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            // Data stand only in the cycle after the strobe
            reg_rdata <= reg_read ? rdata_next : 8'h00;
            // Level output, follows unmasked status
            irq <= |(irq_status_next & irq_mask_reg);
        end
    end

    // Frame serializer; its outputs are its own flops
    tx_frame_serializer #(
        .COUNT_WIDTH(COUNT_WIDTH)
    ) serializer (
        .clock(clock),
        .rst(rst),
        .start(cmd_tx_start),
        .byte_count(tx_byte_count),
        .extra_bits(tx_extra_bits),
        .parity_en(control_reg[`CTL_PARITY_GEN_BIT]),
        .tx_data(tx_data),
        .byte_take(tx_byte_take),
        .tx_bit(tx_bit),
        .tx_bit_valid(tx_bit_valid),
        .busy(tx_busy),
        .done(tx_done)
    );
endmodule
`default_nettype wire

// ==== frame_regs_consts.vh ====
/*
 * Constants of the frame length and collision register bank: register
 * offsets, field positions, reset values and interrupt bit layout.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef FRAME_REGS_CONSTS_VH
`define FRAME_REGS_CONSTS_VH

// Register offsets on the 8-bit register port
`define OFS_COLL_POS 8'h20
`define OFS_TGT_STATE 8'h21
`define OFS_TX_CNT_UP 8'h22
`define OFS_TX_CNT_LO 8'h23
`define OFS_IRQ_STATUS 8'h30
`define OFS_IRQ_MASK 8'h31
`define OFS_CONTROL 8'h32

// Reset values
`define RST_TX_CNT 8'h00
`define RST_COLL_POS 8'h00
`define RST_IRQ_MASK 8'h00
`define RST_CONTROL 8'h00

// Interrupt status bits
`define IRQ_COLL_BIT 0
`define IRQ_TXDONE_BIT 1
`define IRQ_HARD_FRAMING_BIT 4
`define IRQ_PARITY_BIT 6

// Control register bits
`define CTL_ANTICOLL_BIT 0
`define CTL_PARITY_GEN_BIT 1

// Target state codes
`define TGT_POWER_OFF 4'h0
`define TGT_IDLE 4'h1
`define TGT_READY_ONE 4'h2
`define TGT_READY_TWO 4'h3
`define TGT_ACTIVE 4'h5
`define TGT_HALT 4'h9
`define TGT_READY_ONE_STAR 4'ha
`define TGT_READY_TWO_STAR 4'hb
`define TGT_ACTIVE_STAR 4'hd

// Bits per full byte
`define BITS_PER_BYTE 4'h8

`endif

// ==== frame_regs_properties.sv ====
/* Checker for the frame length and collision register bank.
   Assumes a bind to the top module; read data follow the strobe by one cycle. */
`timescale 1ns/1ps
`default_nettype none
module frame_regs_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Receiver events
    input wire logic rx_frame_start,
    input wire logic rx_anticoll_cmd,
    input wire logic rx_collision,
    input wire logic [3:0] rx_coll_bytes,
    input wire logic [2:0] rx_coll_bits,
    input wire logic rx_coll_in_parity,
    // Target state and transmit
    input wire logic [3:0] target_state,
    input wire logic [7:0] tx_data,
    input wire logic tx_byte_take,
    input wire logic tx_bit,
    input wire logic tx_bit_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Capture then an immediate read of the collision place
    sequence s_coll;
        rx_collision && rx_anticoll_cmd ##1 reg_read && reg_addr == 8'h20;
    endsequence
    property p_coll_bytes;
        s_coll |=> reg_rdata[7:4] == $past(rx_coll_bytes, 2);
    endproperty
    a_coll_bytes: assert property (p_coll_bytes) else $error("collision byte count wrong");
    property p_coll_bits;
        s_coll |=> reg_rdata[3:1] == $past(rx_coll_bits, 2);
    endproperty
    a_coll_bits: assert property (p_coll_bits) else $error("collision bit count wrong");
    property p_coll_par;
        s_coll |=> reg_rdata[0] == $past(rx_coll_in_parity, 2);
    endproperty
    a_coll_par: assert property (p_coll_par) else $error("parity collision flag wrong");
    // Without an anticollision event two reads agree
    property p_coll_keep;
        reg_read && reg_addr == 8'h20 && !(rx_anticoll_cmd && (rx_collision || rx_frame_start))
            ##1 reg_read && reg_addr == 8'h20 |=> $stable(reg_rdata);
    endproperty
    a_coll_keep: assert property (p_coll_keep) else $error("collision place changed");
    // Display lags the state input by one cycle
    property p_tgt;
        reg_read && reg_addr == 8'h21 && !$past(rst) |=> reg_rdata == {4'h0, $past(target_state, 2)};
    endproperty
    a_tgt: assert property (p_tgt) else $error("target state display wrong");
    property p_cnt_hi;
        reg_write && reg_addr == 8'h22 ##1 reg_read && reg_addr == 8'h22 |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("upper count readback wrong");
    property p_cnt_lo;
        reg_write && reg_addr == 8'h23 ##1 reg_read && reg_addr == 8'h23 |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_cnt_lo: assert property (p_cnt_lo) else $error("lower count readback wrong");
    property p_take_bit;
        tx_byte_take |=> tx_bit_valid;
    endproperty
    a_take_bit: assert property (p_take_bit) else $error("no bit after byte load");
    property p_lsb;
        tx_byte_take |=> tx_bit == $past(tx_data[0]);
    endproperty
    a_lsb: assert property (p_lsb) else $error("first bit is not the low bit");
    // Read data read zero outside the cycle after a read strobe
    property p_rdata_idle;
        !reg_read |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
    c_coll: cover property (s_coll);
    c_take: cover property (tx_byte_take);
    c_tgt: cover property (reg_read && reg_addr == 8'h21);
endmodule
bind frame_length_collision_regs frame_regs_checker frame_regs_checker_inst (.clock, .rst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .rx_frame_start, .rx_anticoll_cmd, .rx_collision,
    .rx_coll_bytes, .rx_coll_bits, .rx_coll_in_parity, .target_state, .tx_data, .tx_byte_take, .tx_bit,
    .tx_bit_valid);
`default_nettype wire

// ==== tb_frame_length_collision_regs.sv ====
/* Testbench for the frame length and collision register bank.
   Assumes the byte source model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb_frame_length_collision_regs;
    // Stimulus and observed signals
    logic clock, rst, reg_write, reg_read, rx_frame_start, rx_anticoll_cmd;
    logic rx_collision, rx_coll_in_parity, rx_hard_framing_error, cmd_req_or_wakeup, cmd_tx_start;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data;
    logic [3:0] rx_coll_bytes, target_state;
    logic [2:0] rx_coll_bits;
    logic tx_byte_take, tx_bit, tx_bit_valid, tx_busy, irq;
    logic [15:0] bits;
    int nb, n_errors, compares, cyc, i;
    logic [3:0] codes [0:8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h9, 4'ha, 4'hb, 4'hd};
    frame_length_collision_regs frame_length_collision_regs_inst (.clock, .rst, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .rx_frame_start, .rx_anticoll_cmd, .rx_collision,
        .rx_coll_bytes, .rx_coll_bits, .rx_coll_in_parity, .rx_hard_framing_error, .target_state,
        .cmd_req_or_wakeup, .cmd_tx_start, .tx_data, .tx_byte_take, .tx_bit, .tx_bit_valid, .tx_busy, .irq);
    tx_byte_source tx_byte_source_inst (.clock, .rst, .tx_byte_take, .tx_data);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Line capture in send order, and hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (tx_bit_valid === 1'b1) begin
            bits[nb] <= tx_bit;
            nb <= nb + 1;
        end
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(name, {8'h00, reg_rdata}, {8'h00, exp});
    endtask
    // One-cycle pulse of {frame start, collision, hard framing, request}
    task automatic ev(input logic [3:0] which);
        @(posedge clock);
        {rx_frame_start, rx_collision, rx_hard_framing_error, cmd_req_or_wakeup} <= which;
        @(posedge clock);
        {rx_frame_start, rx_collision, rx_hard_framing_error, cmd_req_or_wakeup} <= 4'h0;
    endtask
    // Start a frame and wait for the line to go quiet
    task automatic send();
        @(posedge clock);
        nb <= 0;
        cmd_tx_start <= 1'b1;
        @(posedge clock);
        cmd_tx_start <= 1'b0;
        i = 0;
        do begin
            @(negedge clock);
            i++;
        end while (tx_busy === 1'b1 && i < 300);
    endtask
    task automatic wrap_up();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        {rst, reg_write, reg_read, rx_frame_start, rx_anticoll_cmd, rx_collision} = 6'h20;
        {rx_coll_in_parity, rx_hard_framing_error, cmd_req_or_wakeup, cmd_tx_start} = 4'h0;
        {reg_addr, reg_wdata, rx_coll_bytes, target_state, rx_coll_bits} = 27'h0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(8'h22, 8'h00, "count high");
        rd(8'h23, 8'h00, "count low");
        wr(8'h22, 8'ha5);
        wr(8'h23, 8'h5b);
        wr(8'h20, 8'hff);
        rd(8'h22, 8'ha5, "count high");
        rd(8'h23, 8'h5b, "count low");
        rd(8'h20, 8'h00, "collision");
        rd(8'h7f, 8'h00, "unmapped");
        // Each of the nine target state codes reads back through 21h
        for (int k = 0; k < 9; k++) begin
            @(posedge clock);
            target_state <= codes[k];
            rd(8'h21, {4'h0, codes[k]}, "target");
        end
        @(posedge clock);
        rx_anticoll_cmd <= 1'b1;
        {rx_coll_bytes, rx_coll_bits, rx_coll_in_parity} <= 8'h57;
        ev(4'h4);
        rd(8'h20, 8'h57, "collision");
        {rx_coll_bytes, rx_coll_bits, rx_coll_in_parity} <= 8'ha2;
        ev(4'h4);
        rd(8'h20, 8'ha2, "collision");
        @(posedge clock);
        rx_anticoll_cmd <= 1'b0;
        ev(4'h4);
        rd(8'h20, 8'ha2, "collision");
        ev(4'h8);
        rd(8'h20, 8'ha2, "collision");
        @(posedge clock);
        rx_anticoll_cmd <= 1'b1;
        // Collision followed at once by a read of its place
        @(posedge clock);
        {rx_coll_bytes, rx_coll_bits, rx_coll_in_parity} <= 8'h3d;
        rx_collision <= 1'b1;
        @(posedge clock);
        rx_collision <= 1'b0;
        reg_addr <= 8'h20;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk("collision", {8'h00, reg_rdata}, 16'h003d);
        ev(4'h8);
        rd(8'h20, 8'h00, "collision");
        wr(8'h30, 8'hff);
        wr(8'h31, 8'h52);
        // Events set their status bits; irq only for bits enabled in the mask
        ev(4'h2);
        rd(8'h30, 8'h10, "status");
        chk("irq", irq, 1'b1);
        wr(8'h30, 8'h10);
        rd(8'h30, 8'h00, "status");
        ev(4'h4);
        rd(8'h30, 8'h01, "status");
        chk("irq", irq, 1'b0);
        wr(8'h30, 8'h01);
        wr(8'h32, 8'h01);
        @(posedge clock);
        target_state <= 4'h1;
        ev(4'h1);
        rd(8'h30, 8'h40, "status");
        chk("irq", irq, 1'b1);
        wr(8'h30, 8'h40);
        wr(8'h23, 8'h58);
        ev(4'h1);
        rd(8'h30, 8'h00, "status");
        // Short frames by plain transmit: 11 bits with trailing bits and no parity, then 9 bits with parity
        wr(8'h22, 8'h00);
        wr(8'h23, 8'h0b);
        wr(8'h32, 8'h02);
        send();
        chk("bit count", 16'(nb), 16'd11);
        chk("line bits", bits & 16'h07ff, 16'h0496);
        rd(8'h30, 8'h02, "status");
        wr(8'h30, 8'h02);
        wr(8'h23, 8'h08);
        send();
        chk("bit count", 16'(nb), 16'd9);
        chk("busy", tx_busy, 1'b0);
        chk("line bits", bits & 16'h01ff, 16'h00a7);
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== tx_byte_source.sv ====
/* Byte source model feeding the transmit serializer.
   Assumes one byte is consumed per take pulse; wraps after four. */
`timescale 1ns/1ps
`default_nettype none
module tx_byte_source (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serializer side
    input wire logic tx_byte_take,
    output logic [7:0] tx_data
);
    // Bytes offered in order
    logic [7:0] mem [0:3] = '{8'h96, 8'h3c, 8'ha7, 8'h5a};
    logic [1:0] idx_reg;
    assign tx_data = mem[idx_reg];
    // Advance only once the byte was latched
    always @(posedge clock) begin
        if (rst) begin
            idx_reg <= 2'h0;
        end else if (tx_byte_take) begin
            idx_reg <= idx_reg + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ==== tx_frame_serializer.v ====
/*
 * Transmit frame serializer: sends a count of full bytes and then a
 * trailing partial byte, least significant bit first, one bit per clock within a byte and a load cycle before each byte.
 * Assumes the byte source holds the next byte on tx_data whenever a load
 * happens and advances after each byte_take pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "frame_regs_consts.vh"

module tx_frame_serializer #(
    parameter COUNT_WIDTH = 13
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Frame request
    input wire start,
    input wire [COUNT_WIDTH-1:0] byte_count,
    input wire [2:0] extra_bits,
    input wire parity_en,
    // Byte source
    input wire [7:0] tx_data,
    output reg byte_take,
    // Bit stream
    output reg tx_bit,
    output reg tx_bit_valid,
    output reg busy,
    output reg done
);
    // One-hot states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_LOAD = 4'h2;
    localparam [3:0] ST_SHIFT = 4'h4;
    localparam [3:0] ST_PAR = 4'h8;

    reg [3:0] state_reg; // Sequencer state
    reg [COUNT_WIDTH-1:0] bytes_left_reg; // Full bytes still to send
    reg [2:0] extra_left_reg; // Trailing bits still pending
    reg [7:0] shift_reg; // Byte on its way out
    reg [3:0] bits_left_reg; // Bits left of current byte
    reg par_acc_reg; // Running xor of byte data
    reg par_on_reg; // Parity generation for this frame

    // Sequencer; one bit leaves per clock while shifting
    always @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            bytes_left_reg <= {COUNT_WIDTH{1'b0}};
            extra_left_reg <= 3'h0;
            shift_reg <= 8'h00;
            bits_left_reg <= 4'h0;
            par_acc_reg <= 1'b0;
            par_on_reg <= 1'b0;
            byte_take <= 1'b0;
            tx_bit <= 1'b0;
            tx_bit_valid <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            byte_take <= 1'b0;
            tx_bit_valid <= 1'b0;
            done <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // Start taken only while idle
                    if (start) begin
                        bytes_left_reg <= byte_count;
                        extra_left_reg <= extra_bits;
                        par_on_reg <= parity_en && (extra_bits == 3'h0);
                        busy <= 1'b1;
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    par_acc_reg <= 1'b0;
                    if (bytes_left_reg != {COUNT_WIDTH{1'b0}}) begin
                        shift_reg <= tx_data;
                        bits_left_reg <= `BITS_PER_BYTE;
                        bytes_left_reg <= bytes_left_reg - 1'b1;
                        byte_take <= 1'b1;
                        state_reg <= ST_SHIFT;
                    end else if (extra_left_reg != 3'h0) begin
                        shift_reg <= tx_data;
                        bits_left_reg <= {1'b0, extra_left_reg};
                        extra_left_reg <= 3'h0;
                        byte_take <= 1'b1;
                        state_reg <= ST_SHIFT;
                    end else begin
                        // Nothing left, frame complete
                        busy <= 1'b0;
                        done <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_SHIFT: begin
                    tx_bit <= shift_reg[0];
                    tx_bit_valid <= 1'b1;
                    shift_reg <= {1'b0, shift_reg[7:1]};
                    par_acc_reg <= par_acc_reg ^ shift_reg[0];
                    bits_left_reg <= bits_left_reg - 1'b1;
                    if (bits_left_reg == 4'h1) begin
                        state_reg <= par_on_reg ? ST_PAR : ST_LOAD;
                    end
                end
                ST_PAR: begin
                    // Odd parity over the byte just sent
                    tx_bit <= ~par_acc_reg;
                    tx_bit_valid <= 1'b1;
                    state_reg <= ST_LOAD;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire
